// *** logic/cmsd_regs.svh ***
/*
  Register offsets, field positions, reset values and counts for the
  control mode strap decode block.
  Assumes inclusion by its bare name from the package and design file.
*/
`ifndef CMSD_REGS_SVH
`define CMSD_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CMSD_OFS_MASTER_CONFIG  8'h00
`define CMSD_OFS_CLOCK_CHOICE   8'h04
`define CMSD_OFS_STATUS         8'h08
`define CMSD_OFS_LOSS           8'h0c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CMSD_MC_CLK_EN_BIT      0
`define CMSD_MC_RESET           1'h0
`define CMSD_CCR_MSB            1
`define CMSD_CCR_RESET          2'h0
`define CMSD_RDATA_ZERO         32'h0000_0000

// ----------------------------------------------------------------------
// Clock output divider half periods less one cycle, one per clock choice
// ----------------------------------------------------------------------
`define CMSD_HALF_DIV0          8'h01
`define CMSD_HALF_DIV1          8'h03
`define CMSD_HALF_DIV2          8'h07
`define CMSD_HALF_DIV3          8'h0f

// ----------------------------------------------------------------------
// Loss of signal counts in clock cycles
// ----------------------------------------------------------------------
`define CMSD_LOS_SET_CYCLES     8'hc0
`define CMSD_LOS_CLR_WINDOW     8'hc0
`define CMSD_LOS_CLR_MARKS      8'h18
`define CMSD_CNT_ZERO           8'h00
`define CMSD_CNT_ONE            8'h01
`define CMSD_CNT_MAX            8'hff

`endif

// *** logic/cmsd_pkg.sv ***
/*
  Types for the control mode strap decode block.
  Assumes cmsd_regs.svh is on the include path.
*/
package cmsd_pkg;

  `include "cmsd_regs.svh"

  typedef enum logic [1:0] {
    CMSD_MODE_HW,
    CMSD_MODE_SERIAL,
    CMSD_MODE_PARALLEL
  } cmsd_mode_t;

  // Synchronised strap levels.
  typedef struct packed {
    logic [1:0] style_level;
    logic       addr_data_share;
    logic       imp_select;
    logic       bus_style;
    logic       line_is_e1;
    logic       scan_select;
  } cmsd_strap_t;

  // Decoded configuration handed to the rest of the device.
  typedef struct packed {
    logic serial_host;
    logic parallel_host;
    logic addr_data_muxed;
    logic strobe_separate;
    logic imp_high;
    logic ami_coding;
    logic scan_test;
    logic scan_shift;
  } cmsd_cfg_t;

endpackage

// *** logic/cmsd_top.sv ***
/*
  Control mode strap decode: straps, host bus style, hardware-mode line
  settings, scan controls, loss of signal outputs and the programmable
  auxiliary clock, with an AHB-Lite register slave.
  Assumes straps and line marks are asynchronous and pass two flops, and
  that a three-level comparator turns the mode pin into two bits.
*/
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
// Behaviour
// RULE1: Scan-select high enters scan test; low is normal; pull-down keeps it low.
// RULE2: Scan-shift on the eighth loss pin works only while scan-select is high.
// RULE3: Aux clock driven only when master config enables it; clock choice sets rate.
// RULE4: Hardware mode never offers the aux clock output.
// RULE5: Mode pin low hardware, mid serial host, high parallel host.
// RULE6: Parallel host: sharing select high muxes address/data, low separates them.
// RULE7: Hardware mode: impedance pin low 75/100 ohm, high 120/110 ohm.
// RULE8: Default-120 variant inverts impedance meaning in E1 mode only.
// RULE9: Parallel host: bus style low read/write line, high separate strobes.
// RULE10: Hardware mode: coding pin high AMI, low B8ZS or HDB3.
// RULE11: Loss outputs rise with no transitions, fall on enough ones density.
// RULE12: Dual-function pins act only in the currently decoded mode.
// RULE13: Board holds the strap pins static during operation.
`timescale 1ns/10ps
`include "cmsd_regs.svh"

module cmsd_top
  import cmsd_pkg::*;
#(
  parameter bit IMP_DEFAULT_120 = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic [1:0]  control_style_select,
  input  wire logic        addr_data_share_select,
  input  wire logic        line_impedance_select,
  input  wire logic        host_bus_style_select,
  input  wire logic        line_is_e1,
  input  wire logic        scan_select,
  input  wire logic [7:0]  rx_mark,
  output logic [6:0]       signal_loss_out,
  input  wire logic        signal_loss_out_ch8_in,
  output logic             signal_loss_out_ch8,
  output logic             signal_loss_out_ch8_oe,
  output logic             aux_prog_clock_out,
  output logic             aux_prog_clock_out_oe,
  output cmsd_mode_t       control_mode,
  output cmsd_cfg_t        decoded_cfg
);

  // --------------------------------------------------------------------
  // Synchronisers
  // --------------------------------------------------------------------
  cmsd_strap_t strap_meta;
  cmsd_strap_t strap;
  logic        ch8_meta;
  logic        ch8_in;
  logic [7:0]  mark_meta;
  logic [7:0]  mark_sync;
  logic [7:0]  mark_prev;
  cmsd_strap_t strap_raw;

  // Straps are meant to stay still. The two mode bits are synchronised
  // separately, so a pin moved in operation may show a wrong mode for one
  // cycle before the decode settles.
  // Mode pin has no clock relation to clk_sys, so all straps are synced.
  assign strap_raw = '{style_level:     control_style_select,
                       addr_data_share: addr_data_share_select,
                       imp_select:      line_impedance_select,
                       bus_style:       host_bus_style_select,
                       line_is_e1:      line_is_e1,
                       scan_select:     scan_select};

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      strap_meta <= '0;
      strap      <= '0;
      ch8_meta   <= 1'b0;
      ch8_in     <= 1'b0;
      mark_meta  <= 8'h00;
      mark_sync  <= 8'h00;
      mark_prev  <= 8'h00;
    end else begin
      strap_meta <= strap_raw;
      strap      <= strap_meta;
      ch8_meta   <= signal_loss_out_ch8_in;
      ch8_in     <= ch8_meta;
      mark_meta  <= rx_mark;
      mark_sync  <= mark_meta;
      mark_prev  <= mark_sync;
    end
  end

  // --------------------------------------------------------------------
  // Mode and strap decode
  // --------------------------------------------------------------------
  cmsd_mode_t mode;
  logic       in_hw;
  logic       in_par;
  logic       in_ser;
  logic       imp_invert;

  // RULE5: three-level decode.
  // The odd code 10 cannot come from a sane comparator; treating it as
  // mid-supply matches the pin's own bias when it floats.
  assign mode = (strap.style_level == 2'b00) ? CMSD_MODE_HW :
                (strap.style_level == 2'b11) ? CMSD_MODE_PARALLEL :
                CMSD_MODE_SERIAL;
  assign in_hw  = (mode == CMSD_MODE_HW);
  assign in_par = (mode == CMSD_MODE_PARALLEL);
  assign in_ser = (mode == CMSD_MODE_SERIAL);

  // RULE8: variant inversion, E1 only.
  assign imp_invert = IMP_DEFAULT_120 & strap.line_is_e1;

  always_comb begin
    decoded_cfg             = '0;
    decoded_cfg.serial_host = in_ser;
    decoded_cfg.parallel_host = in_par;
    // RULE1: scan test select.
    decoded_cfg.scan_test   = strap.scan_select;
    // RULE2: shift gated by scan select.
    decoded_cfg.scan_shift  = strap.scan_select & ch8_in;
    // RULE12: shared pins read per mode.
    case (mode)
      CMSD_MODE_PARALLEL: begin
        // RULE6: address and data sharing.
        decoded_cfg.addr_data_muxed = strap.addr_data_share;
        // RULE9: host bus strobe style.
        decoded_cfg.strobe_separate = strap.bus_style;
      end
      CMSD_MODE_HW: begin
        // RULE7: line impedance choice.
        decoded_cfg.imp_high   = strap.imp_select ^ imp_invert;
        // RULE10: line code choice.
        decoded_cfg.ami_coding = strap.bus_style;
      end
      default: begin
        decoded_cfg.addr_data_muxed = 1'b0;
      end
    endcase
  end

  assign control_mode = mode;

  // --------------------------------------------------------------------
  // Shared arithmetic
  // --------------------------------------------------------------------
  // Counters stop at all ones, so no count can wrap back into range.
  function automatic logic [7:0] cnt_step(input logic [7:0] value);
    cnt_step = (value == `CMSD_CNT_MAX) ? value : value + `CMSD_CNT_ONE;
  endfunction

  // One byte offset compare serves both the write and the read decode.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  // --------------------------------------------------------------------
  // Register slave
  // --------------------------------------------------------------------
  logic        mc_clk_en;
  logic [1:0]  ccr_choice;
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic        ap_take;
  logic [7:0]  ap_addr;
  logic [31:0] next_rdata;
  logic [7:0]  los_vec;
  logic        wr_mc;
  logic        wr_ccr;
  logic        rd_mc;
  logic        rd_ccr;
  logic        rd_status;
  logic        rd_loss;

  // Zero wait states: every access completes in its first data cycle.
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign ap_take   = hsel & htrans[1] & hready;
  assign ap_addr   = haddr[7:0];
  assign wr_mc     = dp_write & reg_hit(dp_addr, `CMSD_OFS_MASTER_CONFIG);
  assign wr_ccr    = dp_write & reg_hit(dp_addr, `CMSD_OFS_CLOCK_CHOICE);
  assign rd_mc     = reg_hit(ap_addr, `CMSD_OFS_MASTER_CONFIG);
  assign rd_ccr    = reg_hit(ap_addr, `CMSD_OFS_CLOCK_CHOICE);
  assign rd_status = reg_hit(ap_addr, `CMSD_OFS_STATUS);
  assign rd_loss   = reg_hit(ap_addr, `CMSD_OFS_LOSS);

  // Transfer size is ignored: each register is one whole word, so a
  // narrow write still lands on every field of the word.
  assign next_rdata =
    rd_mc     ? {31'h0, mc_clk_en} :
    rd_ccr    ? {30'h0, ccr_choice} :
    rd_status ? {22'h0, mode, decoded_cfg} :
    rd_loss   ? {24'h0, los_vec} :
    `CMSD_RDATA_ZERO;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dp_write <= 1'b0;
      dp_addr  <= 8'h00;
      hrdata   <= `CMSD_RDATA_ZERO;
    end else begin
      dp_write <= ap_take & hwrite;
      dp_addr  <= ap_addr;
      // Read data is captured in the address phase, so a read right behind
      // a write to the same register still returns the old value.
      if (ap_take & ~hwrite) begin
        hrdata <= next_rdata;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      mc_clk_en  <= `CMSD_MC_RESET;
      ccr_choice <= `CMSD_CCR_RESET;
    end else begin
      // RULE3: enable and rate registers.
      if (wr_mc) begin
        mc_clk_en <= hwdata[`CMSD_MC_CLK_EN_BIT];
      end
      if (wr_ccr) begin
        ccr_choice <= hwdata[`CMSD_CCR_MSB:0];
      end
    end
  end

  // --------------------------------------------------------------------
  // Programmable auxiliary clock
  // --------------------------------------------------------------------
  function automatic logic [7:0] half_div(input logic [1:0] sel);
    case (sel)
      2'h0:    half_div = `CMSD_HALF_DIV0;
      2'h1:    half_div = `CMSD_HALF_DIV1;
      2'h2:    half_div = `CMSD_HALF_DIV2;
      default: half_div = `CMSD_HALF_DIV3;
    endcase
  endfunction

  logic       aux_run;
  logic [7:0] div_cnt;
  logic       div_wrap;

  // RULE3: enable from master config.
  // RULE4: never in hardware mode.
  assign aux_run  = mc_clk_en & ~in_hw;
  assign div_wrap = (div_cnt >= half_div(ccr_choice));

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      div_cnt               <= `CMSD_CNT_ZERO;
      aux_prog_clock_out    <= 1'b0;
      aux_prog_clock_out_oe <= 1'b0;
    end else begin
      // The enable is registered beside the clock, so both leave the pin
      // on the same edge when the output is switched off.
      aux_prog_clock_out_oe <= aux_run;
      if (!aux_run || div_wrap) begin
        div_cnt <= `CMSD_CNT_ZERO;
      end else begin
        div_cnt <= cnt_step(div_cnt);
      end
      if (!aux_run) begin
        aux_prog_clock_out <= 1'b0;
      end else if (div_wrap) begin
        aux_prog_clock_out <= ~aux_prog_clock_out;
      end
    end
  end

  // --------------------------------------------------------------------
  // Loss of signal detection
  // --------------------------------------------------------------------
  logic [7:0] zero_cnt [8];
  logic [7:0] win_cnt  [8];
  logic [7:0] mark_cnt [8];
  logic [7:0] los;
  logic [7:0] edge_seen;

  assign edge_seen = mark_sync ^ mark_prev;
  assign los_vec   = los;

  // RULE11: silence sets, density clears.
  // The clear test uses a fixed window, so a channel recovers only after
  // one full window of marks; that trades speed for immunity to noise.
  // Only one of the quiet and window counts runs at a time per channel.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      los <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        zero_cnt[i] <= `CMSD_CNT_ZERO;
        win_cnt[i]  <= `CMSD_CNT_ZERO;
        mark_cnt[i] <= `CMSD_CNT_ZERO;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (!los[i]) begin
          win_cnt[i]  <= `CMSD_CNT_ZERO;
          mark_cnt[i] <= `CMSD_CNT_ZERO;
          if (edge_seen[i]) begin
            zero_cnt[i] <= `CMSD_CNT_ZERO;
          end else if (zero_cnt[i] >= `CMSD_LOS_SET_CYCLES) begin
            los[i]      <= 1'b1;
            zero_cnt[i] <= `CMSD_CNT_ZERO;
          end else begin
            zero_cnt[i] <= cnt_step(zero_cnt[i]);
          end
        end else if (win_cnt[i] >= `CMSD_LOS_CLR_WINDOW) begin
          win_cnt[i]  <= `CMSD_CNT_ZERO;
          mark_cnt[i] <= `CMSD_CNT_ZERO;
          if (mark_cnt[i] >= `CMSD_LOS_CLR_MARKS) begin
            los[i] <= 1'b0;
          end
        end else begin
          win_cnt[i] <= cnt_step(win_cnt[i]);
          if (edge_seen[i]) begin
            mark_cnt[i] <= cnt_step(mark_cnt[i]);
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Loss outputs and the shared eighth pin
  // --------------------------------------------------------------------
  assign signal_loss_out     = los[6:0];
  assign signal_loss_out_ch8 = los[7];

  // RULE2: pin is an input in scan.
  // The eighth pin turns round only on the synchronised select, so its
  // drive may lag the select pin by two cycles.
  assign signal_loss_out_ch8_oe = ~strap.scan_select;

endmodule

// *** tb/cmsd_top_monitor.sv ***
/*
  Port checker for the strap decode block.
  Assumes a bind into cmsd_top, one clock and a reset active high.
*/
`timescale 1ns/10ps

module cmsd_top_monitor
  import cmsd_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [7:0] rx_mark,
  input wire logic [6:0] signal_loss_out,
  input wire logic       signal_loss_out_ch8_oe,
  input wire logic       aux_prog_clock_out,
  input wire logic       aux_prog_clock_out_oe,
  input wire cmsd_mode_t control_mode,
  input wire cmsd_cfg_t  decoded_cfg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ----------------------------------------------------------------
  // Quiet time on channel one
  // ----------------------------------------------------------------
  // The count saturates, so a long idle line never wraps below the bound.
  logic       last_mark;
  logic [8:0] quiet;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      last_mark <= 1'b0;
      quiet     <= 9'h000;
    end else begin
      last_mark <= rx_mark[0];
      quiet     <= (rx_mark[0] != last_mark) ? 9'h000 : quiet + {8'h00, quiet != 9'h1ff};
    end
  end

  chk_scan_drive: assert property (signal_loss_out_ch8_oe == !decoded_cfg.scan_test)
    else $error("eighth loss pin drive disagrees with scan test");
  chk_shift_gate: assert property (decoded_cfg.scan_shift |-> decoded_cfg.scan_test)
    else $error("scan shift outside scan test");
  chk_aux_half: assert property ($rose(aux_prog_clock_out) |=> aux_prog_clock_out)
    else $error("aux clock high for one cycle only");
  chk_aux_idle: assert property (!aux_prog_clock_out_oe [*3] |-> !aux_prog_clock_out)
    else $error("aux clock moves while released");
  chk_aux_hwmode: assert property ((control_mode == CMSD_MODE_HW) [*2] |-> !aux_prog_clock_out_oe)
    else $error("aux clock driven in hardware mode");
  chk_mode_par: assert property (decoded_cfg.parallel_host == (control_mode == CMSD_MODE_PARALLEL))
    else $error("parallel flag disagrees with mode");
  chk_mode_ser: assert property (decoded_cfg.serial_host == (control_mode == CMSD_MODE_SERIAL))
    else $error("serial flag disagrees with mode");
  chk_par_fields: assert property (!decoded_cfg.parallel_host |->
    !decoded_cfg.addr_data_muxed && !decoded_cfg.strobe_separate) else $error("bus fields set off parallel");
  chk_hw_fields: assert property (control_mode != CMSD_MODE_HW |->
    !decoded_cfg.imp_high && !decoded_cfg.ami_coding) else $error("line fields set off hardware");
  chk_loss_set: assert property (quiet >= 9'h0dc |-> signal_loss_out[0])
    else $error("quiet line without loss");
  chk_loss_early: assert property ($rose(signal_loss_out[0]) |-> quiet >= 9'h0b4)
    else $error("loss raised on an active line");

  cov_parallel: cover property (decoded_cfg.parallel_host && decoded_cfg.addr_data_muxed);
  cov_aux_on: cover property ($rose(aux_prog_clock_out_oe));
  cov_loss: cover property ($rose(signal_loss_out[0]));
endmodule

bind cmsd_top cmsd_top_monitor mon (.clk_sys, .sys_rst, .rx_mark, .signal_loss_out, .signal_loss_out_ch8_oe,
  .aux_prog_clock_out, .aux_prog_clock_out_oe, .control_mode, .decoded_cfg);

// *** tb/cmsd_board.sv ***
/*
  Board model: mode pin with its bias, the shared eighth loss pin and the
  received marks. Assumes the bench picks strap levels per test.
*/
`timescale 1ns/10ps

module cmsd_board (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [1:0] mode_pin,
  input  wire logic       scan_en_pin,
  input  wire logic [7:0] marks_on,
  input  wire logic       ch8_out,
  input  wire logic       ch8_oe,
  output logic [1:0]      control_style_select,
  output logic            ch8_in,
  output logic [7:0]      rx_mark
);
  // static strap wiring
  // Codes 0 low, 1 mid, 2 high, 3 open; the bias settles an open pin at mid.
  assign control_style_select = (mode_pin == 2'h0) ? 2'h0 : (mode_pin == 2'h2) ? 2'h3 : 2'h1;
  // The board drives scan enable only while the device has released the pin.
  assign ch8_in = ch8_oe ? ch8_out : scan_en_pin;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rx_mark <= 8'h00;
    end else begin
      rx_mark <= rx_mark ^ marks_on;
    end
  end
endmodule

// *** tb/tb.sv ***
/*
  Bench: host register tasks, a sweep of all strap levels, aux clock rates
  and loss of signal. Assumes package, board and checker compile first.
*/
`timescale 1ns/10ps

module tb
  import cmsd_pkg::*;
;
  logic        clk_sys, sys_rst, hsel, hwrite, hready, share, imp, style, e1, scan, scan_en_pin;
  logic        ch8_out, ch8_oe, ch8_in, aux, aux_oe, resp;
  logic [1:0]  htrans, mode_pin, control_style_select;
  logic [2:0]  hsize;
  logic [6:0]  loss;
  logic [7:0]  marks_on, rx_mark;
  logic [10:0] want;
  logic [31:0] haddr, hwdata, hrdata, rd;
  cmsd_mode_t  mode;
  cmsd_cfg_t   cfg;
  int          fails, cmp_count, per;

  cmsd_top #(.IMP_DEFAULT_120(1'b1)) uut (
    .clk_sys, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout(hready), .hresp(resp), .control_style_select, .addr_data_share_select(share),
    .line_impedance_select(imp), .host_bus_style_select(style), .line_is_e1(e1), .scan_select(scan),
    .rx_mark, .signal_loss_out(loss), .signal_loss_out_ch8_in(ch8_in), .signal_loss_out_ch8(ch8_out),
    .signal_loss_out_ch8_oe(ch8_oe), .aux_prog_clock_out(aux), .aux_prog_clock_out_oe(aux_oe),
    .control_mode(mode), .decoded_cfg(cfg));

  cmsd_board board (.clk_sys, .sys_rst, .mode_pin, .scan_en_pin, .marks_on, .ch8_out, .ch8_oe,
    .control_style_select, .ch8_in, .rx_mark);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp_v);
    cmp_count++;
    if (got !== exp_v) begin
      fails++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp_v);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      fails++;
      complete_run();
    end
  endtask

  // One single word transfer; read data is taken at the closing edge.
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, resp}, 32'h0);
  endtask

  task automatic wait_aux(input logic v);
    int n;
    n = 0;
    while (aux !== v && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 200) begin
      fails++;
      complete_run();
    end
    per = per + n;
  endtask

  // Strap byte: mode pin, E1, scan enable, scan select, style, impedance, share.
  function automatic logic [10:0] exp_cfg(input logic [7:0] v);
    logic hw, par, ser;
    hw = v[7:6] == 2'h0;
    par = v[7:6] == 2'h2;
    ser = v[6];
    return {!v[3], par, ser, ser, par, par & v[0], par & v[2], hw & (v[1] ^ v[5]), hw & v[2], v[3], v[3] & v[4]};
  endfunction

  initial begin
    fails = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    {mode_pin, e1, scan_en_pin, scan, style, imp, share} = 8'h00;
    marks_on = 8'hff;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    bus(32'h0, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(32'h4, 1'b0, 32'h0);
    chk(rd, 32'h0);
    bus(32'h20, 1'b1, 32'hffff_ffff);
    bus(32'h20, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 256; i++) begin
      {mode_pin, e1, scan_en_pin, scan, style, imp, share} <= i[7:0];
      repeat (5) @(posedge clk_sys);
      want = exp_cfg(i[7:0]);
      chk({21'h0, ch8_oe, mode, cfg}, {21'h0, want});
      bus(32'h8, 1'b0, 32'h0);
      chk(rd, {22'h0, want[9:0]});
    end
    $display("test straps done");
    {mode_pin, e1, scan_en_pin, scan, style, imp, share} <= 8'h80;
    bus(32'h0, 1'b1, 32'h1);
    for (int k = 0; k < 4; k++) begin
      bus(32'h4, 1'b1, 32'(k));
      bus(32'h4, 1'b0, 32'h0);
      chk(rd, 32'(k));
      wait_aux(1'b0);
      wait_aux(1'b1);
      per = 0;
      wait_aux(1'b0);
      wait_aux(1'b1);
      chk({31'h0, aux_oe}, 32'h1);
      chk(32'(per), 32'h4 << k);
    end
    bus(32'h0, 1'b1, 32'h0);
    repeat (3) @(posedge clk_sys);
    chk({30'h0, aux_oe, aux}, 32'h0);
    {mode_pin, e1, scan_en_pin, scan, style, imp, share} <= 8'h00;
    bus(32'h0, 1'b1, 32'h1);
    repeat (4) @(posedge clk_sys);
    chk({30'h0, aux_oe, aux}, 32'h0);
    $display("test aux clock done");
    marks_on <= 8'hf0;
    repeat (300) @(posedge clk_sys);
    chk({24'h0, ch8_out, loss}, 32'h0f);
    bus(32'hc, 1'b0, 32'h0);
    chk(rd, 32'h0f);
    marks_on <= 8'h0f;
    repeat (450) @(posedge clk_sys);
    chk({24'h0, ch8_out, loss}, 32'hf0);
    $display("test loss done");
    complete_run();
  end
endmodule
